// ==== cfp_config_protect.sv ====
// Configuration words, code protection and code memory behind the
// executive command port.
// Assumes one command at a time; the port holds a command until taken.
// Behaviour
// - Prescale bit set divides watchdog clock by 128, clear by 32.
// - Postscale field selects ratio; 1111 is 1:32768, each lower halves.
// - Power-on delay doubles from 2 ms at 001 to 128 ms; 000 disables.
// - Debug mode bit one gives user mode out of reset, zero debug.
// - Channel 11 primary, 10 first alternate, 01 second; 00 reserved.
// - Unimplemented configuration bits are read-only and read zero.
// - Bulk erase leaves system operation configuration words unchanged.
// - General read protection field at 10 blocks code reads.
// - Code programming fails under write protection or read protection; unit id words stay programmable.
// - Code reads return zero while read protection is active.
// - Bulk erase sets every code-protection bit to one.
// - Protection bits only go one to zero by programming.
// - Any cleared protection bit refuses code changes until bulk erase.
// - Unit identifier area of 32 words at 0x8005c0 to 0x8005ff.
// - Erase sets every affected location to all ones.
// - Row erase spares protection bits; system and identity not erasable.
// - Configuration read returns 16-bit values only.
// - Code read returns 24-bit words, addresses up to 32K words.
// - Reads of unmapped locations fault the executive; absent code inside the code span reads zero.
`timescale 1ns/1ps
module cfp_config_protect
	import cfp_pkg::*;
#(
	parameter int              CODE_WORDS = 4096,
	parameter int              ROW_WORDS  = 32,
	parameter int              MS_CYCLES  = CFP_MS_CYCLES,
	// Arbitrary identity value
	parameter logic [15:0]     DEVICE_ID  = 16'h0000
) (
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	input  wire logic          cmd_valid,
	output logic               cmd_ready,
	input  wire cfp_cmd_type   cmd,
	output logic               rsp_valid,
	output cfp_rsp_type        rsp,
	output logic [7:0]         watchdog_prescale_div,
	output logic [15:0]        watchdog_postscale_div,
	output logic               power_on_delay_done,
	output logic               debug_mode,
	output logic [2:0]         debug_channel_onehot,
	output logic               debug_channel_reserved,
	output logic               write_protected,
	output logic               read_protected
);

	localparam int AW = $clog2(CODE_WORDS);

	// The unit id index is taken from the low five bits of the word index
	if (CODE_WORDS < ROW_WORDS || CODE_WORDS < CFP_UID_WORDS
		|| (CODE_WORDS & (CODE_WORDS - 1)) != 0
		|| (ROW_WORDS & (ROW_WORDS - 1)) != 0
		|| CODE_WORDS * 2 > int'(CFP_CODE_SPAN)) begin : g_bad_size
		$error("CODE_WORDS or ROW_WORDS unsupported");
	end

	typedef enum logic [2:0] {
		CFP_IDLE,
		CFP_READ_WAIT,
		CFP_WRITE_CHECK,
		CFP_ERASE_WALK
	} cfp_fsm_type;

	typedef struct packed {
		cfp_fsm_type           st;
		logic [CFP_CFG_W-1:0]  wdt;
		logic [CFP_CFG_W-1:0]  por;
		logic [CFP_CFG_W-1:0]  dbg;
		logic [CFP_CFG_W-1:0]  boot;
		logic [CFP_CFG_W-1:0]  gen;
		logic [AW-1:0]         idx;
		logic [AW-1:0]         last;
		logic [CFP_WORD_W-1:0] data;
		logic                  uid_sel;
		logic                  rsp_valid;
		cfp_rsp_type           rsp;
		logic                  dbg_mode;
		logic                  dbg_latched;
	} cfp_state_type;

	cfp_state_type         s_q;
	cfp_state_type         s_d;

	// Flash arrays are nonvolatile: no reset, erased only by command
	logic [CFP_WORD_W-1:0] code_mem [CODE_WORDS];
	logic [CFP_WORD_W-1:0] uid_mem  [CFP_UID_WORDS];
	logic [CFP_WORD_W-1:0] code_rd_q;
	logic [CFP_WORD_W-1:0] uid_rd_q;
	logic [AW-1:0]         rd_idx;
	logic [4:0]            uid_idx;
	logic                  mem_we;
	logic                  uid_we;
	logic [AW-1:0]         we_idx;
	logic [CFP_WORD_W-1:0] we_data;

	logic                  in_span;
	logic                  in_phys;
	logic                  in_uid;
	logic                  in_cfg;
	logic [2:0]            cfg_sel;
	logic [CFP_ADDR_W-1:0] cfg_off;
	logic [CFP_CFG_W-1:0]  cfg_word;
	logic [2:0]            boot_rp;
	logic                  any_prot_clear;
	logic [CFP_WORD_W-1:0] merged;

	// Address decode
	assign in_span = cmd.addr < CFP_CODE_SPAN;
	assign in_phys = cmd.addr < CFP_ADDR_W'(CODE_WORDS * 2);
	assign in_uid  = cmd.addr >= CFP_UID_FIRST
		&& cmd.addr <= CFP_UID_LAST;
	assign cfg_off = cmd.addr - CFP_CFG_BASE;
	assign cfg_sel = cfg_off[3:1];
	assign in_cfg  = cmd.addr >= CFP_CFG_BASE && !cfg_off[0]
		&& cfg_off[CFP_ADDR_W-1:4] == '0 && cfg_sel <= CFP_CFG_ID;
	assign rd_idx  = (s_q.st == CFP_IDLE) ? cmd.addr[AW:1] : s_q.idx;
	assign uid_idx = cmd.addr[5:1];

	// Protection state
	assign boot_rp = s_q.boot[CFP_BOOT_RP_LSB +: 3];
	assign write_protected = !s_q.boot[CFP_BOOT_WP_BIT]
		|| !s_q.gen[CFP_GEN_WP_BIT];
	assign read_protected = s_q.gen[CFP_GEN_RP_LSB +: 2] == CFP_GEN_RP_ON
		|| boot_rp == CFP_BOOT_STD_S || boot_rp == CFP_BOOT_STD_M
		|| boot_rp == CFP_BOOT_HIGH_S
		|| boot_rp == CFP_BOOT_HIGH_M;
	assign any_prot_clear = (s_q.boot != CFP_BOOT_MASK)
		|| (s_q.gen != CFP_GEN_MASK);

	// Flash cells only clear on programming; verify sees the result
	assign merged = code_rd_q & s_q.data;

	always_comb begin
		unique case (cfg_sel)
			CFP_CFG_WDT:  cfg_word = s_q.wdt;
			CFP_CFG_POR:  cfg_word = s_q.por;
			CFP_CFG_DBG:  cfg_word = s_q.dbg;
			CFP_CFG_BOOT: cfg_word = s_q.boot;
			CFP_CFG_GEN:  cfg_word = s_q.gen;
			CFP_CFG_ID:   cfg_word = DEVICE_ID;
			default:      cfg_word = '0;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.rsp_valid = 1'b0;
		mem_we  = 1'b0;
		uid_we  = 1'b0;
		we_idx  = s_q.idx;
		we_data = '1;
		// Mode is taken when the power-on delay ends, so a setting
		// written during the delay still decides this start-up
		if (!s_q.dbg_latched && power_on_delay_done) begin
			s_d.dbg_latched = 1'b1;
			s_d.dbg_mode = !s_q.dbg[CFP_DBG_MODE_BIT];
		end
		unique case (s_q.st)
			CFP_IDLE: begin
				if (cmd_valid) begin
					s_d.rsp_valid = 1'b1;
					s_d.rsp = '{ok: 1'b1, fault: 1'b0, data: '0};
					s_d.data = cmd.data;
					s_d.idx = cmd.addr[AW:1];
					s_d.uid_sel = in_uid;
					unique case (cmd.op)
						CFP_CONFIG_WRITE_CMD: begin
							if (!in_cfg) begin
								s_d.rsp.ok = 1'b0;
								s_d.rsp.fault = 1'b1;
							end else begin
								unique case (cfg_sel)
									CFP_CFG_WDT: s_d.wdt =
										cmd.data[15:0] & CFP_WDT_MASK;
									CFP_CFG_POR: s_d.por =
										cmd.data[15:0] & CFP_POR_MASK;
									CFP_CFG_DBG: s_d.dbg =
										cmd.data[15:0] & CFP_DBG_MASK;
									CFP_CFG_BOOT: s_d.boot =
										s_q.boot & cmd.data[15:0];
									CFP_CFG_GEN: s_d.gen =
										s_q.gen & cmd.data[15:0];
									default: s_d.rsp.ok = 1'b0;
								endcase
							end
						end
						CFP_CONFIG_READ_CMD: begin
							if (in_cfg) begin
								s_d.rsp.data = {8'h00, cfg_word};
							end else begin
								s_d.rsp.ok = 1'b0;
								s_d.rsp.fault = 1'b1;
							end
						end
						CFP_CODE_READ_CMD: begin
							if ((in_phys && !read_protected) || in_uid) begin
								s_d.rsp_valid = 1'b0;
								s_d.st = CFP_READ_WAIT;
							end else if (!in_span && !in_uid) begin
								s_d.rsp.ok = 1'b0;
								s_d.rsp.fault = 1'b1;
							end else begin
								// Protected or absent code reads as zero
								s_d.rsp.data = '0;
							end
						end
						CFP_CODE_WRITE_CMD: begin
							if (!in_phys && !in_uid) begin
								s_d.rsp.ok = 1'b0;
								s_d.rsp.fault = 1'b1;
							end else if (!in_uid && (write_protected
								|| read_protected || any_prot_clear)) begin
								s_d.rsp.ok = 1'b0;
							end else begin
								s_d.rsp_valid = 1'b0;
								s_d.st = CFP_WRITE_CHECK;
							end
						end
						CFP_BULK_ERASE_CMD: begin
							s_d.boot = CFP_BOOT_MASK;
							s_d.gen  = CFP_GEN_MASK;
							// System words are left alone on purpose
							s_d.idx  = '0;
							s_d.last = '1;
							s_d.rsp_valid = 1'b0;
							s_d.st = CFP_ERASE_WALK;
						end
						CFP_ROW_ERASE_CMD: begin
							if (!in_phys) begin
								s_d.rsp.ok = 1'b0;
								s_d.rsp.fault = 1'b1;
							end else if (write_protected || any_prot_clear) begin
								s_d.rsp.ok = 1'b0;
							end else begin
								// Protection words untouched here
								s_d.idx = cmd.addr[AW:1]
									& ~AW'(ROW_WORDS - 1);
								s_d.last = cmd.addr[AW:1]
									| AW'(ROW_WORDS - 1);
								s_d.rsp_valid = 1'b0;
								s_d.st = CFP_ERASE_WALK;
							end
						end
						default: begin
							s_d.rsp.ok = 1'b0;
						end
					endcase
				end
			end
			CFP_READ_WAIT: begin
				s_d.rsp_valid = 1'b1;
				s_d.rsp = '{ok: 1'b1, fault: 1'b0,
					data: s_q.uid_sel ? uid_rd_q : code_rd_q};
				s_d.st = CFP_IDLE;
			end
			CFP_WRITE_CHECK: begin
				// Programming cannot set a bit; verify catches it
				mem_we  = !s_q.uid_sel;
				uid_we  = s_q.uid_sel;
				we_data = s_q.uid_sel ? uid_rd_q & s_q.data : merged;
				s_d.rsp_valid = 1'b1;
				s_d.rsp = '{ok: we_data == s_q.data, fault: 1'b0,
					data: we_data};
				s_d.st = CFP_IDLE;
			end
			CFP_ERASE_WALK: begin
				// One word per cycle keeps the array single-ported
				mem_we  = 1'b1;
				we_data = '1;
				s_d.idx = s_q.idx + AW'(1);
				if (s_q.idx == s_q.last) begin
					s_d.rsp_valid = 1'b1;
					s_d.rsp = '{ok: 1'b1, fault: 1'b0, data: '0};
					s_d.st = CFP_IDLE;
				end
			end
			default: begin
				s_d.st = CFP_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: CFP_IDLE, wdt: CFP_WDT_MASK, por: CFP_POR_MASK,
				dbg: CFP_DBG_MASK, boot: CFP_BOOT_MASK, gen: CFP_GEN_MASK,
				idx: '0, last: '0, data: '0, uid_sel: 1'b0,
				rsp_valid: 1'b0, rsp: '0, dbg_mode: 1'b0,
				dbg_latched: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		code_rd_q <= code_mem[rd_idx];
		uid_rd_q  <= uid_mem[(s_q.st == CFP_IDLE) ? uid_idx
			: s_q.idx[4:0]];
		if (mem_we) begin
			code_mem[we_idx] <= we_data;
		end
		if (uid_we) begin
			uid_mem[s_q.idx[4:0]] <= we_data;
		end
	end

	assign cmd_ready = s_q.st == CFP_IDLE;
	assign rsp_valid = s_q.rsp_valid;
	assign rsp       = s_q.rsp;

	// Decoded system settings
	assign watchdog_prescale_div = s_q.wdt[CFP_WDT_PRE_BIT]
		? CFP_PRE_DIV_HI : CFP_PRE_DIV_LO;
	assign watchdog_postscale_div =
		16'(17'h00001 << s_q.wdt[CFP_WDT_POST_LSB +: 4]);
	assign debug_mode = s_q.dbg_mode;

	generate
		for (genvar i = 0; i < 3; i++) begin : g_ch
			localparam logic [1:0] CODE = (i == 0) ? CFP_CH_PRIMARY
				: (i == 1) ? CFP_CH_ALT1 : CFP_CH_ALT2;
			assign debug_channel_onehot[i] =
				s_q.dbg[CFP_DBG_CH_LSB +: 2] == CODE;
		end
	endgenerate
	assign debug_channel_reserved = s_q.dbg[CFP_DBG_CH_LSB +: 2] == 2'h0;

	cfp_por_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_por (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.delay_sel (s_q.por[CFP_POR_SEL_LSB +: 3]),
		.por_done  (power_on_delay_done)
	);

endmodule

// ==== cfp_config_protect_chk.sv ====
// Checker for the command port and decoded outputs.
// Assumes it sees only the ports of cfp_config_protect.
`timescale 1ns/1ps
module cfp_config_protect_chk
	import cfp_pkg::*;
#(
	parameter int CODE_WORDS = 4096,
	parameter int ROW_WORDS  = 32,
	parameter int MS_CYCLES  = CFP_MS_CYCLES
) (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire cfp_cmd_type cmd,
	input wire logic        rsp_valid,
	input wire cfp_rsp_type rsp,
	input wire logic [7:0]  watchdog_prescale_div,
	input wire logic [15:0] watchdog_postscale_div,
	input wire logic        power_on_delay_done,
	input wire logic        debug_mode,
	input wire logic [2:0]  debug_channel_onehot,
	input wire logic        debug_channel_reserved,
	input wire logic        write_protected,
	input wire logic        read_protected
);
	cfp_cmd_op_type op_q;
	logic [23:0]    addr_q;
	logic           take;
	assign take = cmd_valid && cmd_ready;
	// Remembers the last taken command so answers can be judged by kind
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_q   <= CFP_CONFIG_WRITE_CMD;
			addr_q <= '0;
		end else if (take) begin
			op_q   <= cmd.op;
			addr_q <= cmd.addr;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	cfg_answer_a: assert property (take && (cmd.op == CFP_CONFIG_READ_CMD ||
		cmd.op == CFP_CONFIG_WRITE_CMD) |=> rsp_valid)
		else $error("config command not answered next cycle");
	code_rd_lat_a: assert property (take && cmd.op == CFP_CODE_READ_CMD &&
		!read_protected && cmd.addr < 24'(2 * CODE_WORDS)
		|=> !cmd_ready && !rsp_valid ##1 rsp_valid)
		else $error("code read answer timing wrong");
	bulk_busy_a: assert property (take && cmd.op == CFP_BULK_ERASE_CMD
		|=> (!cmd_ready && !rsp_valid) [*8])
		else $error("bulk erase finished too early");
	cfg_width_a: assert property (rsp_valid && op_q == CFP_CONFIG_READ_CMD
		|-> rsp.data[23:16] == 8'h00)
		else $error("config read wider than 16 bits");
	unimpl_zero_a: assert property (rsp_valid && op_q == CFP_CONFIG_READ_CMD
		&& addr_q == CFP_CFG_BASE
		|-> (rsp.data[15:0] & ~CFP_WDT_MASK) == 16'h0000)
		else $error("unimplemented config bit read as one");
	rp_zero_a: assert property (rsp_valid && op_q == CFP_CODE_READ_CMD &&
		read_protected && addr_q < CFP_CODE_SPAN |-> rsp.data == 24'h0)
		else $error("protected code read returned data");
	wp_refuse_a: assert property (rsp_valid && (op_q == CFP_CODE_WRITE_CMD ||
		op_q == CFP_ROW_ERASE_CMD) && (write_protected || read_protected)
		|-> !rsp.ok)
		else $error("protected code change accepted");
	bulk_unprot_a: assert property (rsp_valid && op_q == CFP_BULK_ERASE_CMD
		|-> !write_protected && !read_protected)
		else $error("protection left on after bulk erase");
	pre_div_a: assert property (take && cmd.op == CFP_CONFIG_WRITE_CMD &&
		cmd.addr == CFP_CFG_BASE |=> ##1 watchdog_prescale_div ==
		($past(cmd.data[CFP_WDT_PRE_BIT], 2) ? CFP_PRE_DIV_HI
		: CFP_PRE_DIV_LO))
		else $error("prescale divider does not follow bit");
	post_pow2_a: assert property (rst_n |-> $onehot(watchdog_postscale_div))
		else $error("postscale ratio not a power of two");
	chan_res_a: assert property (debug_channel_reserved
		|-> debug_channel_onehot == 3'h0)
		else $error("reserved channel still routes a pair");
endmodule

bind cfp_config_protect cfp_config_protect_chk #(.CODE_WORDS(CODE_WORDS),
	.ROW_WORDS(ROW_WORDS), .MS_CYCLES(MS_CYCLES)) i_cfp_config_protect_chk (
	.sys_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp,
	.watchdog_prescale_div, .watchdog_postscale_div, .power_on_delay_done,
	.debug_mode, .debug_channel_onehot, .debug_channel_reserved,
	.write_protected, .read_protected);

// ==== cfp_config_protect_tb.sv ====
// Self-checking bench for the configuration and protection block.
// Assumes the programmer model drives every command.
`timescale 1ns/1ps
module cfp_config_protect_tb;
	import cfp_pkg::*;
	localparam int          CW  = 64;
	localparam int          MSC = 4;
	localparam logic [25:0] MA  = 26'h3ffffff;
	localparam logic [25:0] MST = 26'h3000000;
	localparam logic [25:0] OK  = 26'h2000000;
	localparam logic [25:0] BAD = 26'h0000000;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmd_valid, cmd_ready, rsp_valid, power_on_delay_done;
	cfp_cmd_type cmd;
	cfp_rsp_type rsp;
	logic [7:0]  watchdog_prescale_div;
	logic [15:0] watchdog_postscale_div;
	logic        debug_mode, debug_channel_reserved;
	logic        write_protected, read_protected;
	logic [2:0]  debug_channel_onehot;
	int          err_total = 0;
	int          n_tests = 0;
	integer      seed = 32'hd6bc3895;
	logic [25:0] exp_q[$];
	logic [25:0] msk_q[$];

	initial forever #12.5 sys_clk = ~sys_clk;

	cfp_config_protect #(.CODE_WORDS(CW), .ROW_WORDS(8), .MS_CYCLES(MSC))
		i_cfp_config_protect (.sys_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd,
		.rsp_valid, .rsp, .watchdog_prescale_div, .watchdog_postscale_div,
		.power_on_delay_done, .debug_mode, .debug_channel_onehot,
		.debug_channel_reserved, .write_protected, .read_protected);
	cfp_prog_model i_cfp_prog_model (.sys_clk, .cmd_ready, .cmd_valid, .cmd);

	task automatic check(logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic issue(cfp_cmd_op_type o, logic [23:0] a, logic [23:0] d,
		logic [25:0] e, logic [25:0] m);
		bit to;
		exp_q.push_back(e);
		msk_q.push_back(m);
		i_cfp_prog_model.send(o, a, d, to);
		if (to) begin
			check(32'h0, 32'h1);
			tally_and_finish();
		end
	endtask
	task automatic drain();
		for (int i = 0; i < 1000 && exp_q.size() > 0; i++) begin
			@(negedge sys_clk);
		end
		if (exp_q.size() > 0) begin
			check(32'h0, 32'h1);
			tally_and_finish();
		end
	endtask
	function automatic logic [23:0] ca(int i);
		return CFP_CFG_BASE + 24'(2 * i);
	endfunction
	task automatic wr(int i, logic [23:0] d);
		issue(CFP_CONFIG_WRITE_CMD, ca(i), d, OK, MST);
	endtask
	task automatic rd(int i, logic [15:0] e);
		issue(CFP_CONFIG_READ_CMD, ca(i), 24'h0, OK | 26'(e), MA);
	endtask
	task automatic code(cfp_cmd_op_type o, logic [23:0] a, logic [23:0] d,
		logic [25:0] e, logic [25:0] m);
		issue(o, a, d, e, m);
	endtask

	// Answers are matched in order against the notes the driver left
	always @(negedge sys_clk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(32'(rsp), 32'h1);
			end else begin
				check(32'(rsp & msk_q[0]), 32'(exp_q[0]));
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
		end
	end

	initial begin
		int n;
		logic [23:0] d;
		logic [23:0] d2;
		logic [1:0] c;
		time t0;
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		t0 = $time;
		wr(2, 24'h000003);
		drain();
		n = 0;
		while (power_on_delay_done !== 1'b1 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		check(32'(($time - t0) / CFP_CLK_NS >= MSC * 128 - 1
			&& ($time - t0) / CFP_CLK_NS <= MSC * 128 + 1), 32'h1);
		@(negedge sys_clk);
		check(watchdog_prescale_div, CFP_PRE_DIV_HI);
		check(watchdog_postscale_div, 16'h8000);
		check({debug_mode, debug_channel_reserved, debug_channel_onehot},
			5'h11);
		code(CFP_BULK_ERASE_CMD, 24'h0, 24'h0, OK, MST);
		rd(0, CFP_WDT_MASK);
		rd(1, CFP_POR_MASK);
		rd(2, 16'h0003);
		rd(3, CFP_BOOT_MASK);
		rd(4, CFP_GEN_MASK);
		repeat (6) begin
			d = 24'($random(seed));
			wr(0, d);
			rd(0, d[15:0] & CFP_WDT_MASK);
			drain();
			check(watchdog_prescale_div, d[4] ? CFP_PRE_DIV_HI
				: CFP_PRE_DIV_LO);
			check(watchdog_postscale_div, 16'h1 << d[3:0]);
		end
		for (int k = 0; k < 4; k++) begin
			c = 2'(k);
			wr(2, {8'h0, 8'h80, 6'h0, c});
			drain();
			check({debug_channel_reserved, debug_channel_onehot},
				{c == 2'h0, c == 2'h1, c == 2'h2, c == 2'h3});
		end
		code(CFP_BULK_ERASE_CMD, 24'h0, 24'h0, OK, MST);
		rd(0, d[15:0] & CFP_WDT_MASK);
		d = 24'($random(seed));
		d2 = ~d;
		code(CFP_CODE_WRITE_CMD, 24'h40, d, OK | 26'(d), MA);
		code(CFP_CODE_READ_CMD, 24'h40, 24'h0, OK | 26'(d), MA);
		code(CFP_CODE_WRITE_CMD, 24'h40, d2, {d2 == 24'h0, 25'h0}, MA);
		rd(3, CFP_BOOT_MASK);
		code(CFP_ROW_ERASE_CMD, 24'h40, 24'h0, OK, MST);
		code(CFP_CODE_READ_CMD, 24'h40, 24'h0, OK | 26'hffffff, MA);
		code(CFP_CODE_READ_CMD, 24'h00fffe, 24'h0, OK, MA);
		code(CFP_CODE_READ_CMD, 24'h010000, 24'h0, 26'h1000000, MST);
		code(CFP_CODE_READ_CMD, CFP_UID_LAST - 24'h1, 24'h0, OK, MST);
		code(CFP_CODE_READ_CMD, CFP_UID_LAST + 24'h1, 24'h0, 26'h1000000,
			MST);
		issue(CFP_CONFIG_WRITE_CMD, ca(5), 24'h0, BAD, MST);
		issue(CFP_CONFIG_READ_CMD, ca(6), 24'h0, 26'h1000000, MST);
		wr(4, 24'h5);
		drain();
		check({write_protected, read_protected}, 2'h1);
		code(CFP_CODE_READ_CMD, 24'h40, 24'h0, OK, MA);
		code(CFP_CODE_WRITE_CMD, 24'h42, 24'h0, BAD, MST);
		code(CFP_ROW_ERASE_CMD, 24'h40, 24'h0, BAD, MST);
		wr(4, 24'h7);
		rd(4, 16'h0005);
		code(CFP_BULK_ERASE_CMD, 24'h0, 24'h0, OK, MST);
		rd(4, CFP_GEN_MASK);
		wr(3, 24'he);
		drain();
		check({write_protected, read_protected}, 2'h2);
		code(CFP_CODE_WRITE_CMD, 24'h44, 24'h0, BAD, MST);
		code(CFP_ROW_ERASE_CMD, 24'h40, 24'h0, BAD, MST);
		rd(3, 16'h000e);
		code(CFP_CODE_READ_CMD, 24'h40, 24'h0, OK | 26'hffffff, MA);
		code(CFP_BULK_ERASE_CMD, 24'h0, 24'h0, OK, MST);
		drain();
		check({write_protected, read_protected}, 2'h0);
		check(32'(exp_q.size()), 32'h0);
		tally_and_finish();
	end
endmodule

// ==== cfp_pkg.sv ====
// Shared constants and carriers for the configuration and protection block.
// Assumes word addresses step by two, as in instruction address space.
package cfp_pkg;

	localparam int CFP_ADDR_W = 24;
	localparam int CFP_WORD_W = 24;
	localparam int CFP_CFG_W  = 16;

	// Command set seen by the on-chip executive
	typedef enum logic [2:0] {
		CFP_CONFIG_WRITE_CMD,
		CFP_CONFIG_READ_CMD,
		CFP_CODE_READ_CMD,
		CFP_CODE_WRITE_CMD,
		CFP_BULK_ERASE_CMD,
		CFP_ROW_ERASE_CMD
	} cfp_cmd_op_type;

	typedef struct packed {
		cfp_cmd_op_type        op;
		logic [CFP_ADDR_W-1:0] addr;
		logic [CFP_WORD_W-1:0] data;
	} cfp_cmd_type;

	typedef struct packed {
		logic                  ok;
		logic                  fault;
		logic [CFP_WORD_W-1:0] data;
	} cfp_rsp_type;

	// Address map
	localparam logic [CFP_ADDR_W-1:0] CFP_CODE_SPAN = 24'h010000;
	localparam logic [CFP_ADDR_W-1:0] CFP_UID_FIRST = 24'h8005c0;
	localparam logic [CFP_ADDR_W-1:0] CFP_UID_LAST  = 24'h8005ff;
	localparam int                    CFP_UID_WORDS = 32;
	localparam logic [CFP_ADDR_W-1:0] CFP_CFG_BASE  = 24'hf80000;
	localparam logic [2:0] CFP_CFG_WDT  = 3'h0;
	localparam logic [2:0] CFP_CFG_POR  = 3'h1;
	localparam logic [2:0] CFP_CFG_DBG  = 3'h2;
	localparam logic [2:0] CFP_CFG_BOOT = 3'h3;
	localparam logic [2:0] CFP_CFG_GEN  = 3'h4;
	localparam logic [2:0] CFP_CFG_ID   = 3'h5;

	// Field positions
	localparam int CFP_WDT_POST_LSB = 0;
	localparam int CFP_WDT_PRE_BIT  = 4;
	localparam int CFP_POR_SEL_LSB  = 0;
	localparam int CFP_DBG_CH_LSB   = 0;
	localparam int CFP_DBG_MODE_BIT = 7;
	localparam int CFP_BOOT_WP_BIT  = 0;
	localparam int CFP_BOOT_RP_LSB  = 1;
	localparam int CFP_GEN_WP_BIT   = 0;
	localparam int CFP_GEN_RP_LSB   = 1;

	// Implemented bits; these are also the erased values
	localparam logic [CFP_CFG_W-1:0] CFP_WDT_MASK  = 16'h00df;
	localparam logic [CFP_CFG_W-1:0] CFP_POR_MASK  = 16'h0007;
	localparam logic [CFP_CFG_W-1:0] CFP_DBG_MASK  = 16'h0083;
	localparam logic [CFP_CFG_W-1:0] CFP_BOOT_MASK = 16'h000f;
	localparam logic [CFP_CFG_W-1:0] CFP_GEN_MASK  = 16'h0007;

	// Decoded field values
	localparam logic [1:0] CFP_GEN_RP_ON   = 2'h2;
	localparam logic [2:0] CFP_BOOT_STD_S  = 3'h6;
	localparam logic [2:0] CFP_BOOT_STD_M  = 3'h5;
	localparam logic [2:0] CFP_BOOT_HIGH_S = 3'h2;
	localparam logic [2:0] CFP_BOOT_HIGH_M = 3'h1;
	localparam logic [1:0] CFP_CH_PRIMARY  = 2'h3;
	localparam logic [1:0] CFP_CH_ALT1     = 2'h2;
	localparam logic [1:0] CFP_CH_ALT2     = 2'h1;
	localparam logic [7:0] CFP_PRE_DIV_HI  = 8'h80;
	localparam logic [7:0] CFP_PRE_DIV_LO  = 8'h20;
	localparam logic [2:0] CFP_POR_OFF     = 3'h0;

	// Timing
	localparam int CFP_CLK_NS     = 25;
	localparam int CFP_MS_NS      = 1000000;
	localparam int CFP_MS_CYCLES  = CFP_MS_NS / CFP_CLK_NS;

endpackage

// ==== cfp_por_timer.sv ====
// Power-on delay timer: holds por_done low for 2^sel milliseconds, or not at all when sel is zero.
// Assumes the selection is steady from reset release onward.
`timescale 1ns/1ps
module cfp_por_timer
	import cfp_pkg::*;
#(
	parameter int MS_CYCLES = CFP_MS_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] delay_sel,
	output logic            por_done
);

	// The cycle counter is 20 bits wide
	if (MS_CYCLES < 1 || MS_CYCLES > 1000000) begin : g_bad_ms
		$error("MS_CYCLES out of range");
	end

	typedef struct packed {
		logic [19:0] cyc;
		logic [7:0]  ms;
		logic        done;
	} cfp_por_state_type;

	cfp_por_state_type s_q;
	cfp_por_state_type s_d;
	logic [7:0]        ms_goal;

	assign ms_goal  = 8'(9'h001 << delay_sel);
	assign por_done = s_q.done;

	always_comb begin
		s_d = s_q;
		if (!s_q.done) begin
			if (delay_sel == CFP_POR_OFF) begin
				s_d.done = 1'b1;
			end else if (s_q.cyc == 20'(MS_CYCLES - 1)) begin
				s_d.cyc = '0;
				s_d.ms  = s_q.ms + 8'h01;
				// Doubling from 2 ms at code 1
				if (s_q.ms + 8'h01 == ms_goal) begin
					s_d.done = 1'b1;
				end
			end else begin
				s_d.cyc = s_q.cyc + 20'h00001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

// ==== cfp_prog_model.sv ====
// Programmer model: offers one command at a time on the executive port.
// Assumes cmd_ready comes from the block's state register.
`timescale 1ns/1ps
module cfp_prog_model
	import cfp_pkg::*;
(
	input  wire logic   sys_clk,
	input  wire logic   cmd_ready,
	output logic        cmd_valid,
	output cfp_cmd_type cmd
);
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end
	// Held from a falling edge until the edge that takes it
	task automatic send(cfp_cmd_op_type o, logic [23:0] a, logic [23:0] d,
		output bit to);
		int n;
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd = '{o, a, d};
		n = 0;
		while (cmd_ready !== 1'b1 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		to = (n >= 2000);
		@(posedge sys_clk);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		// Released lines must not keep looking valid
		cmd = cfp_cmd_type'(~cmd);
	endtask
endmodule
